//--- design/iprc_pkg.sv
// Package for the intra-processor route control block: microword field
// positions, route set-up register layout, read-select codes, dispatch address.
// Assumes a 48-bit microword presented for a whole microcycle, phases as enables.
//
// Behaviour
// - data output bus and data input bus are both 16 bits wide.
// - only the D register drives the output bus, continuously, no enable.
// - input bus reaches the datapath only through a scratchpad write.
// - route register holds 16 bits: low five select section, eleven control it.
// - route register loads at P3 when bus-begin, bus-box and route-load are one.
// - route register keeps its path for any number of transfers until reloaded or cleared by clear-flags.
// - no external bus cycle, section transfer or route load unless the bus-begin bit is one.
// - with bus-box set, bits 22 to 20 are route controls, not bus cycle controls.
// - next address bits 11:9 come from page register, loaded from return or word.
// - next address bits 8:0 are base OR branch-test bits; return uses return reg.
// - both call tests and return test load the return register through its mux.
// - forced dispatch overrides page and base with the fixed error address.
// - input bus mux has four inputs; select and enable come from route bits.
// - cleared route register asserts literal select, enabling mux on literal port.
// - mux enabled when not I/O, not inhibited, no transfer inhibit, and proc or literal.
// - read-select field from microword bits 39:38 picks the status source.
// - select 0 presents flags and float status low byte.
// - select 1 presents the processor status word with mode bits doubled.
// - select 2 presents zero, current microaddress, reserved flags, fetch flag.
// - select 3 presents the 16-bit microword literal.
// - external transfer inhibit disables every route-controlled input bus mux.
// - current microaddress loads at P3, holds the faulting address on dispatch.
package iprc_pkg;

  localparam int BUS_W  = 16;
  localparam int UW_W   = 48;
  localparam int UA_W   = 12;
  localparam int PAGE_W = 3;
  localparam int BASE_W = 9;

  // microword bus, route, sequencing and literal field positions
  localparam int UW_BUS_BEGIN    = 24;
  localparam int UW_BUS_BOX      = 23;
  localparam int UW_FLOAT_HW     = 22;
  localparam int UW_SECT_XFER    = 21;
  localparam int UW_ROUTE_LOAD   = 20;
  localparam int UW_PROC_SEL     = 36;
  localparam int UW_IO_SEL       = 46;
  localparam int UW_READ_HI      = 39;
  localparam int UW_READ_LO      = 38;
  localparam int UW_PAGE_HI      = 32;
  localparam int UW_PAGE_LO      = 30;
  localparam int UW_RET_PAGE_HI  = 46;
  localparam int UW_RET_PAGE_LO  = 44;
  localparam int UW_RET_ADDR_HI  = 41;
  localparam int UW_RET_ADDR_LO  = 33;
  localparam int UW_JUMP_HI      = 8;
  localparam int UW_JUMP_LO      = 0;
  localparam int UW_LIT_A_HI     = 47;
  localparam int UW_LIT_A_LO     = 44;
  localparam int UW_LIT_B_HI     = 41;
  localparam int UW_LIT_B_LO     = 30;

  // route set-up register layout
  localparam int RT_PROC_SEL = 0;
  localparam int RT_IO_SEL   = 1;
  localparam int RT_READ_LO  = 5;
  localparam int RT_READ_HI  = 6;
  localparam logic [BUS_W-1:0] RT_RESET = 16'h0000;

  // D register bits that feed the return register
  localparam int D_RET_HI = 14;
  localparam int D_RET_LO = 3;

  typedef enum logic [1:0] {
    IPRC_RD_FLAGS   = 2'h0,
    IPRC_RD_STATUS  = 2'h1,
    IPRC_RD_UADDR   = 2'h2,
    IPRC_RD_LITERAL = 2'h3
  } iprc_read_t;

  // fixed error-service entry, value chosen here
  localparam logic [PAGE_W-1:0] JAM_PAGE = 3'h0;
  localparam logic [BASE_W-1:0] JAM_BASE = 9'h001;

  localparam logic [UA_W-1:0]  UA_RESET  = 12'h000;
  localparam logic [BUS_W-1:0] BUS_ZERO  = 16'h0000;

endpackage : iprc_pkg

//--- design/iprc_din_mux.sv
// Four-input selector for the processor control input bus.
// Assumes the caller registers the result and applies the enable.
module iprc_din_mux
  import iprc_pkg::*;
(
  // selection
  input  wire iprc_pkg::iprc_read_t sel_i,
  // status sources
  input  wire logic [7:0]           flags_i,
  input  wire logic [7:0]           float_status_low_i,
  input  wire logic [BUS_W-1:0]     processor_status_word_i,
  input  wire logic [UA_W-1:0]      current_microaddress_i,
  input  wire logic [2:1]           extra_reserved_flags_i,
  input  wire logic                 overlap_fetch_flag_i,
  input  wire logic [BUS_W-1:0]     microword_literal_i,
  // result
  output logic      [BUS_W-1:0]     data_o
);
  always_comb
  begin
    unique case (sel_i)
      IPRC_RD_FLAGS:
        data_o = {flags_i[3], flags_i[7:4], flags_i[2:0], float_status_low_i};
      IPRC_RD_STATUS:
        data_o = {{2{processor_status_word_i[15]}}, {2{processor_status_word_i[13]}},
                  4'h0, processor_status_word_i[7:0]};
      IPRC_RD_UADDR:
        data_o = {1'b0, current_microaddress_i, extra_reserved_flags_i, overlap_fetch_flag_i};
      IPRC_RD_LITERAL:
        data_o = microword_literal_i;
    endcase
  end
endmodule // iprc_din_mux

//--- design/iprc_route_ctrl.sv
// Route control and next-microaddress formation of the processor control section.
// Assumes phase_p3_i is a one-cycle enable from the microcycle phase divider on
// ref_clk_i, and that microword and branch inputs are stable through the cycle.
module iprc_route_ctrl
  import iprc_pkg::*;
(
  // clock and system clear
  input  wire logic                 ref_clk_i,
  input  wire logic                 rst_i,
  // microcycle phase enable
  input  wire logic                 phase_p3_i,
  // microword
  input  wire logic [UW_W-1:0]      microword_i,
  // branch tests
  input  wire logic [BASE_W-1:0]    branch_test_bits_i,
  input  wire logic                 call_from_d_branch_i,
  input  wire logic                 call_from_word_branch_i,
  input  wire logic                 return_branch_i,
  input  wire logic                 clear_flags_branch_i,
  input  wire logic                 forced_dispatch_i,
  // datapath D register
  input  wire logic                 d_load_i,
  input  wire logic [BUS_W-1:0]     d_data_i,
  // input bus control
  input  wire logic                 route_load_inhibit_i,
  input  wire logic                 external_transfer_inhibit_i,
  input  wire logic [BUS_W-1:0]     din_bus_i,
  input  wire logic                 scratchpad_write_i,
  // status sources
  input  wire logic [7:0]           flags_i,
  input  wire logic [7:0]           float_status_low_i,
  input  wire logic [BUS_W-1:0]     processor_status_word_i,
  input  wire logic [2:1]           extra_reserved_flags_i,
  input  wire logic                 overlap_fetch_flag_i,
  // output bus
  output logic      [BUS_W-1:0]     dout_o,
  // input bus drive
  output logic      [BUS_W-1:0]     din_o,
  output logic                      din_oe_o,
  // scratchpad input mux
  output logic      [BUS_W-1:0]     scratchpad_data_o,
  output logic                      scratchpad_we_o,
  // route state
  output logic      [BUS_W-1:0]     route_setup_reg_o,
  output logic                      literal_select_o,
  output logic                      section_transfer_o,
  output logic                      ext_bus_cycle_o,
  output logic      [2:0]           ext_bus_ctl_o,
  // sequencing
  output logic      [UA_W-1:0]      next_microaddress_o,
  output logic      [UA_W-1:0]      current_microaddress_o,
  output logic      [UA_W-1:0]      return_addr_o
);

  typedef struct packed {
    logic [BUS_W-1:0]  d_reg;
    logic [BUS_W-1:0]  route;
    logic              lit_sel;
    logic [BUS_W-1:0]  din;
    logic              din_oe;
    logic [BUS_W-1:0]  sp_data;
    logic              sp_we;
    logic              sect_xfer;
    logic              ext_cycle;
    logic [2:0]        ext_ctl;
    logic [PAGE_W-1:0] page;
    logic [BASE_W-1:0] base;
    logic [UA_W-1:0]   next_microaddress;
    logic [UA_W-1:0]   current_microaddress;
    logic              cua_hold;
    logic [UA_W-1:0]   ret;
  } iprc_state_t;

  iprc_state_t st;
  iprc_state_t next_st;

  // route register image: word bits scattered across fields gather here
  function automatic logic [BUS_W-1:0] route_image(input logic [UW_W-1:0] mw);
    route_image = {mw[47], mw[45:40], mw[33:32], mw[UW_READ_HI:UW_READ_LO],
                   mw[37], mw[35], mw[34], mw[UW_IO_SEL], mw[UW_PROC_SEL]};
  endfunction

  function automatic logic [BUS_W-1:0] literal_of(input logic [UW_W-1:0] mw);
    literal_of = {mw[UW_LIT_A_HI:UW_LIT_A_LO], mw[UW_LIT_B_HI:UW_LIT_B_LO]};
  endfunction

  logic              bus_begin_bit;
  logic              bus_box_bit;
  logic              route_load_bit;
  logic              section_transfer_bit;
  logic              route_load;
  logic              mux_enable;
  iprc_read_t        read_sel;
  logic [BUS_W-1:0]  mux_data;
  logic [PAGE_W-1:0] page_sel;
  logic [BASE_W-1:0] base_sel;

  assign bus_begin_bit        = microword_i[UW_BUS_BEGIN];
  assign bus_box_bit          = microword_i[UW_BUS_BOX];
  assign route_load_bit       = microword_i[UW_ROUTE_LOAD];
  assign section_transfer_bit = microword_i[UW_SECT_XFER];

  // bit 22 is the float hardware's; microcode keeps it low on route cycles
  assign route_load = bus_begin_bit & bus_box_bit & route_load_bit;

  // enable needs a proc or literal source and no competing driver
  assign mux_enable = ~st.route[RT_IO_SEL] & ~route_load_inhibit_i
                    & (st.route[RT_PROC_SEL] | st.lit_sel)
                    & ~external_transfer_inhibit_i;

  // cleared register forces the literal port
  assign read_sel = st.lit_sel ? IPRC_RD_LITERAL
                  : iprc_read_t'(st.route[RT_READ_HI:RT_READ_LO]);

  iprc_din_mux u_din_mux (
    .sel_i                   (read_sel),
    .flags_i                 (flags_i),
    .float_status_low_i      (float_status_low_i),
    .processor_status_word_i (processor_status_word_i),
    .current_microaddress_i  (st.current_microaddress),
    .extra_reserved_flags_i  (extra_reserved_flags_i),
    .overlap_fetch_flag_i    (overlap_fetch_flag_i),
    .microword_literal_i     (literal_of(microword_i)),
    .data_o                  (mux_data)
  );

  // base from the word, page held unless a call takes it from the word; return register on a return
  always_comb
  begin
    page_sel = st.page;
    base_sel = microword_i[UW_JUMP_HI:UW_JUMP_LO];
    if (return_branch_i)
    begin
      page_sel = st.ret[UA_W-1:BASE_W];
      base_sel = st.ret[BASE_W-1:0];
    end
    else if (call_from_d_branch_i || call_from_word_branch_i)
    begin
      page_sel = microword_i[UW_PAGE_HI:UW_PAGE_LO];
    end
    if (forced_dispatch_i)
    begin
      page_sel = JAM_PAGE;
      base_sel = JAM_BASE;
    end
  end

  always_comb
  begin
    next_st = st;

    // D register drives the output bus with no enable
    if (d_load_i)
    begin
      next_st.d_reg = d_data_i;
    end

    // pulses default low
    next_st.sp_we     = 1'b0;
    next_st.sect_xfer = 1'b0;
    next_st.ext_cycle = 1'b0;

    // input bus drive follows route state each cycle
    next_st.din_oe = mux_enable;
    next_st.din    = mux_enable ? mux_data : BUS_ZERO;

    // input bus data only enters via the scratchpad input mux on a write
    if (scratchpad_write_i)
    begin
      next_st.sp_we   = 1'b1;
      next_st.sp_data = din_bus_i;
    end

    if (phase_p3_i)
    begin
      // path persists until the next load or a clear-flags branch
      if (route_load)
      begin
        next_st.route   = route_image(microword_i);
        next_st.lit_sel = 1'b0;
      end
      else if (clear_flags_branch_i)
      begin
        next_st.route   = RT_RESET;
        next_st.lit_sel = 1'b1;
      end

      // bus-box chooses between route and external bus meaning
      if (bus_begin_bit)
      begin
        if (bus_box_bit)
        begin
          next_st.sect_xfer = section_transfer_bit;
        end
        else
        begin
          next_st.ext_cycle = 1'b1;
          next_st.ext_ctl   = microword_i[UW_FLOAT_HW:UW_ROUTE_LOAD];
        end
      end

      // return register through its mux
      if (call_from_word_branch_i)
      begin
        next_st.ret = {microword_i[UW_RET_PAGE_HI:UW_RET_PAGE_LO],
                       microword_i[UW_RET_ADDR_HI:UW_RET_ADDR_LO]};
      end
      else if (call_from_d_branch_i || return_branch_i)
      begin
        next_st.ret = st.d_reg[D_RET_HI:D_RET_LO];
      end

      next_st.page = page_sel;
      next_st.base = base_sel;
      next_st.next_microaddress  = {page_sel, base_sel | branch_test_bits_i};

      // tracking halts at the faulting instruction; clear-flags resumes it
      if (forced_dispatch_i)
      begin
        next_st.cua_hold = 1'b1;
      end
      else if (clear_flags_branch_i)
      begin
        next_st.cua_hold = 1'b0;
      end
      if (!st.cua_hold && !forced_dispatch_i)
      begin
        next_st.current_microaddress = st.next_microaddress;
      end
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      st          <= '0;
      st.route    <= RT_RESET;
      st.lit_sel  <= 1'b1;
      st.next_microaddress      <= UA_RESET;
      st.current_microaddress      <= UA_RESET;
      st.ret      <= UA_RESET;
    end
    else
    begin
      st <= next_st;
    end
  end

  // all outputs straight from the state register
  assign dout_o                 = st.d_reg;
  assign din_o                  = st.din;
  assign din_oe_o               = st.din_oe;
  assign scratchpad_data_o      = st.sp_data;
  assign scratchpad_we_o        = st.sp_we;
  assign route_setup_reg_o      = st.route;
  assign literal_select_o       = st.lit_sel;
  assign section_transfer_o     = st.sect_xfer;
  assign ext_bus_cycle_o        = st.ext_cycle;
  assign ext_bus_ctl_o          = st.ext_ctl;
  assign next_microaddress_o    = st.next_microaddress;
  assign current_microaddress_o = st.current_microaddress;
  assign return_addr_o          = st.ret;

endmodule // iprc_route_ctrl

//--- test/iprc_route_sva.sv
// Checker for iprc_route_ctrl: route register, input bus mux enable and select, sequencing.
// Assumes it is bound to the route control block; one clock, synchronous active-high clear.
module iprc_route_sva
  import iprc_pkg::*;
(
  // clock and clear
  input wire logic              ref_clk_i,
  input wire logic              rst_i,
  // microword and branch tests
  input wire logic              phase_p3_i,
  input wire logic [UW_W-1:0]   microword_i,
  input wire logic [BASE_W-1:0] branch_test_bits_i,
  input wire logic              call_from_d_branch_i,
  input wire logic              call_from_word_branch_i,
  input wire logic              return_branch_i,
  input wire logic              clear_flags_branch_i,
  input wire logic              forced_dispatch_i,
  input wire logic              route_load_inhibit_i,
  input wire logic              external_transfer_inhibit_i,
  // watched outputs
  input wire logic [BUS_W-1:0]  din_o,
  input wire logic              din_oe_o,
  input wire logic [BUS_W-1:0]  route_setup_reg_o,
  input wire logic              literal_select_o,
  input wire logic [UA_W-1:0]   next_microaddress_o,
  input wire logic [UA_W-1:0]   current_microaddress_o,
  input wire logic [UA_W-1:0]   return_addr_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  wire logic [UW_W-1:0] w  = microword_i;
  wire logic            ld = phase_p3_i & w[24] & w[23] & w[20];
  wire logic            go = phase_p3_i & ~forced_dispatch_i & ~return_branch_i;

  route_load_a:
    assert property (ld |=> route_setup_reg_o == $past({w[47], w[45:40], w[33:32], w[39:38], w[37], w[35], w[34],
      w[46], w[36]}) && !literal_select_o) else $error("route register not loaded");
  route_hold_a:
    assert property (!ld && !(phase_p3_i && clear_flags_branch_i) |=> $stable(route_setup_reg_o))
      else $error("route register changed without load");
  clear_lit_a:
    assert property (phase_p3_i && clear_flags_branch_i && !ld |=> literal_select_o && route_setup_reg_o == RT_RESET)
      else $error("clear flags did not select literal");
  mux_enable_a:
    assert property (1'h1 |=> din_oe_o == $past(!route_setup_reg_o[RT_IO_SEL] && !route_load_inhibit_i &&
      (route_setup_reg_o[RT_PROC_SEL] || literal_select_o) && !external_transfer_inhibit_i))
      else $error("input bus enable wrong");
  mux_literal_a:
    assert property (din_oe_o && $past(literal_select_o || route_setup_reg_o[6:5] == 2'h3)
      |-> din_o == $past({w[47:44], w[41:30]})) else $error("literal port not presented");
  nua_base_a:
    assert property (go |=> next_microaddress_o[8:0] == $past(w[8:0] | branch_test_bits_i))
      else $error("next address low bits wrong");
  page_call_a:
    assert property (go && call_from_word_branch_i && !call_from_d_branch_i |=> next_microaddress_o[11:9] ==
      $past(w[32:30]) && return_addr_o == $past({w[46:44], w[41:33]})) else $error("call page or return wrong");
  ret_jump_a:
    assert property (phase_p3_i && return_branch_i && !forced_dispatch_i |=> next_microaddress_o ==
      $past({return_addr_o[11:9], return_addr_o[8:0] | branch_test_bits_i})) else $error("return jump wrong");
  jam_a:
    assert property (phase_p3_i && forced_dispatch_i && branch_test_bits_i == 9'h000 |=> next_microaddress_o ==
      {JAM_PAGE, JAM_BASE} && $stable(current_microaddress_o)) else $error("forced dispatch wrong");
endmodule // iprc_route_sva

bind iprc_route_ctrl iprc_route_sva u_sva (.*);

//--- test/iprc_far_side.sv
// Model of the other sections on the input bus: bus control with its transfer inhibit.
// Assumes the route block drives route_data_i while route_oe_i is high.
module iprc_far_side (
  // clock
  input  wire logic        ref_clk_i,
  // bench commands
  input  wire logic        xfer_req_i,
  input  wire logic [15:0] ext_data_i,
  // route block drive
  input  wire logic [15:0] route_data_i,
  input  wire logic        route_oe_i,
  // resolved bus
  output logic             inhibit_o,
  output logic      [15:0] din_bus_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] last = 16'h0000;
  assign inhibit_o = xfer_req_i;
  // undriven bus shows the inverse of its last value, never a stale copy
  assign din_bus_o = route_oe_i ? route_data_i : (xfer_req_i ? ext_data_i : ~last);
  always_ff @(posedge ref_clk_i) last <= din_bus_o;
endmodule // iprc_far_side

//--- test/iprc_route_ctrl_bench.sv
// Self-checking bench for iprc_route_ctrl with the far-side bus model and bound checker.
// Assumes 40 MHz ref_clk_i; inputs change 1 ns after each rising edge.
module iprc_route_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import iprc_pkg::*;
  logic                  ref_clk_i = 1'h0, rst_i = 1'h1, phase_p3_i = 1'h0;
  logic [UW_W-1:0]       microword_i = 48'h9000_3ABC_0000;
  logic [BASE_W-1:0]     branch_test_bits_i = 9'h0A5;
  logic                  call_from_d_branch_i = 1'h0, call_from_word_branch_i = 1'h0, return_branch_i = 1'h0;
  logic                  clear_flags_branch_i = 1'h0, forced_dispatch_i = 1'h0, d_load_i = 1'h0;
  logic                  route_load_inhibit_i = 1'h0, scratchpad_write_i = 1'h0, xfer_req = 1'h0;
  logic [BUS_W-1:0]      d_data_i = 16'h0000, ext_data = 16'h1234, processor_status_word_i = 16'hA0C3;
  logic [7:0]            flags_i = 8'hA5, float_status_low_i = 8'h3C;
  logic [2:1]            extra_reserved_flags_i = 2'h2;
  logic                  overlap_fetch_flag_i = 1'h1;
  wire logic [BUS_W-1:0] din_bus_i;
  wire logic             external_transfer_inhibit_i;
  logic [BUS_W-1:0]      dout_o, din_o, scratchpad_data_o, route_setup_reg_o;
  logic                  din_oe_o, scratchpad_we_o, literal_select_o, section_transfer_o, ext_bus_cycle_o;
  logic [2:0]            ext_bus_ctl_o;
  logic [UA_W-1:0]       next_microaddress_o, current_microaddress_o, return_addr_o;
  int                    err_count = 0, n_tests = 0;

  iprc_route_ctrl DUT (.*);
  iprc_far_side far (.ref_clk_i(ref_clk_i), .xfer_req_i(xfer_req), .ext_data_i(ext_data), .route_data_i(din_o),
    .route_oe_i(din_oe_o), .inhibit_o(external_transfer_inhibit_i), .din_bus_o(din_bus_i));

  always #12.5 ref_clk_i = ~ref_clk_i;

  task automatic conclude;
    $display("checks %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic ok);
    n_tests++;
    if (ok !== 1'h1)
    begin
      err_count++;
      $display("MISMATCH at %0t: check %0d", $time, n_tests);
    end
  endtask

  task automatic cyc;
    @(posedge ref_clk_i);
    #1;
  endtask

  task automatic p3(input logic [UW_W-1:0] w);
    microword_i = w;
    phase_p3_i = 1'h1;
    cyc();
    phase_p3_i = 1'h0;
    cyc();
  endtask

  // route load word: float bit stays clear, processor select set
  function automatic logic [UW_W-1:0] rw(input logic [1:0] sel, input logic io);
    rw = 48'h0010_0190_0000 | {io, 6'h0, sel, 38'h0};
  endfunction

  task automatic t_reset;
    chk(route_setup_reg_o === 16'h0000 && literal_select_o === 1'h1);
    chk(din_oe_o === 1'h1 && din_o === {microword_i[47:44], microword_i[41:30]});
  endtask

  task automatic t_status;
    logic [15:0] exp [4];
    exp[0] = {flags_i[3], flags_i[7:4], flags_i[2:0], float_status_low_i};
    exp[1] = {{2{processor_status_word_i[15]}}, {2{processor_status_word_i[13]}}, 4'h0, processor_status_word_i[7:0]};
    exp[2] = {1'h0, 12'h0A5, extra_reserved_flags_i, overlap_fetch_flag_i};
    for (int s = 0; s < 4; s++)
    begin
      p3(rw(s[1:0], 1'h0));
      exp[3] = {microword_i[47:44], microword_i[41:30]};
      chk(route_setup_reg_o === {9'h000, s[1:0], 4'h0, 1'h1});
      chk(din_oe_o === 1'h1 && din_o === exp[s]);
    end
  endtask

  task automatic t_refuse;
    p3(rw(2'h1, 1'h0) ^ 48'h0000_0100_0000);
    chk(route_setup_reg_o === 16'h0061);
    route_load_inhibit_i = 1'h1;
    cyc();
    cyc();
    chk(din_oe_o === 1'h0);
    route_load_inhibit_i = 1'h0;
    p3(rw(2'h3, 1'h1));
    chk(din_oe_o === 1'h0);
    p3(rw(2'h3, 1'h0));
    xfer_req = 1'h1;
    cyc();
    cyc();
    chk(din_oe_o === 1'h0);
    scratchpad_write_i = 1'h1;
    cyc();
    scratchpad_write_i = 1'h0;
    chk(scratchpad_we_o === 1'h1 && scratchpad_data_o === ext_data);
    xfer_req = 1'h0;
    cyc();
    cyc();
    scratchpad_write_i = 1'h1;
    repeat (2)
    begin
      cyc();
      chk(scratchpad_we_o === 1'h1 && scratchpad_data_o === {microword_i[47:44], microword_i[41:30]});
    end
    scratchpad_write_i = 1'h0;
  endtask

  task automatic t_seq;
    call_from_word_branch_i = 1'h1;
    p3({1'h0, 3'h3, 2'h0, 9'h0C3, 3'h5, 21'h0, 9'h10A});
    call_from_word_branch_i = 1'h0;
    chk(next_microaddress_o === 12'hBAF && return_addr_o === 12'h6C3);
    d_data_i = 16'h2B58;
    d_load_i = 1'h1;
    cyc();
    d_load_i = 1'h0;
    chk(dout_o === d_data_i);
    return_branch_i = 1'h1;
    p3(48'h0000_0000_0000);
    return_branch_i = 1'h0;
    chk(next_microaddress_o === 12'h6E7 && return_addr_o === d_data_i[14:3]);
    branch_test_bits_i = 9'h000;
    forced_dispatch_i = 1'h1;
    p3(48'h0000_0000_0000);
    forced_dispatch_i = 1'h0;
    branch_test_bits_i = 9'h0A5;
    chk(next_microaddress_o === {JAM_PAGE, JAM_BASE} && current_microaddress_o === 12'hBAF);
    p3(48'h0000_0000_0000);
    chk(current_microaddress_o === 12'hBAF);
  endtask

  task automatic t_clear;
    clear_flags_branch_i = 1'h1;
    p3(48'hC00F_F000_0000);
    clear_flags_branch_i = 1'h0;
    chk(route_setup_reg_o === 16'h0000 && literal_select_o === 1'h1);
    chk(din_oe_o === 1'h1 && din_o === 16'hC03F);
    p3(48'hC00F_F000_0000);
    chk(current_microaddress_o === 12'h0A5);
  endtask

  // call through D: page from the word, return address from D
  task automatic t_dcall;
    call_from_d_branch_i = 1'h1;
    p3(48'h0000_8000_0003);
    call_from_d_branch_i = 1'h0;
    chk(next_microaddress_o === 12'h4A7 && return_addr_o === d_data_i[14:3]);
  endtask

  // bus-box splits bits 22:20 between route and external meaning
  task automatic t_bus;
    logic [UW_W-1:0] w [3];
    logic [4:0]      e [3];
    w[0] = 48'h0000_01A0_0000;
    w[1] = 48'h0000_0150_0000;
    w[2] = 48'h0000_00A0_0000;
    e[0] = 5'h10;
    e[1] = 5'h0D;
    e[2] = 5'h05;
    for (int i = 0; i < 3; i++)
    begin
      microword_i = w[i];
      phase_p3_i = 1'h1;
      cyc();
      chk({section_transfer_o, ext_bus_cycle_o, ext_bus_ctl_o} === e[i]);
      phase_p3_i = 1'h0;
      cyc();
      chk({section_transfer_o, ext_bus_cycle_o} === 2'h0);
    end
  endtask

  // system clear in mid-run drops a loaded path back to the literal port
  task automatic t_sysclr;
    p3(rw(2'h2, 1'h0));
    chk(route_setup_reg_o === 16'h0041 && literal_select_o === 1'h0);
    rst_i = 1'h1;
    repeat (2) cyc();
    rst_i = 1'h0;
    cyc();
    chk(route_setup_reg_o === 16'h0000 && literal_select_o === 1'h1 && return_addr_o === 12'h000);
    cyc();
    chk(din_oe_o === 1'h1 && current_microaddress_o === 12'h000);
  endtask

  // the whole run needs about 54 cycles; the limit allows 800
  initial
  begin
    #20_000;
    err_count++;
    conclude();
  end

  initial
  begin
    repeat (2) cyc();
    rst_i = 1'h0;
    cyc();
    cyc();
    t_reset();
    t_status();
    t_refuse();
    t_seq();
    t_clear();
    t_dcall();
    t_bus();
    t_sysclr();
    conclude();
  end
endmodule // iprc_route_ctrl_bench
